// ===== plsbc_top.sv
// Slave link buffer status, control and command policy registers.
//
// Summary of operation
// [R1] Link state machine runs while enable bit set.
// [R2] Arriving packet sets buffer-full flag and count.
// [R3] Host writes one to clear buffer-full flag.
// [R4] Data-out request refused while buffer full.
// [R5] Host clears flag after reading received data.
// [R6] Bits five, four show bulk initiator/receiver.
// [R7] Bulk: both buffers full flag, refuse data-out.
// [R8] Flag set when last poll over 268.5ms.
// [R9] Poll timeout only flags, no other action.
// [R10] Resume request bit auto-clears when resume done.
// [R11] Continuous stream auto-sends packets after done; the block re-arms the run only in bulk mode as initiator.
// [R12] Host loads next packet before previous done.
// [R13] Policy bit seven refuses FIFO system request.
// [R14] Policy bit six refuses seal system request.
// [R15] Policy bit five refuses UART requests, default.
// [R16] Policy bit four refuses idle system request.
// [R17] Swap bit gives host RAM readback.
// [R18] Host keeps swap clear when triggering.
// [R19] Run trigger starts command, clears when sent.
// [R20] Received count stored minus one, seven bits.
// [R21] Unused policy bits ignore writes, read zero.
`timescale 1ns/1ps
`include "plsbc_consts.svh"
module plsbc_top #(
  parameter int PING_TO_CYC = `PLSBC_PING_TO_CYC,
  parameter int FIFO_DEPTH  = 32
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  // Register port
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // Link engine events
  input  wire logic                 ping_seen,
  input  wire plsbc_pkg::plsbc_req_s link_req,
  output plsbc_pkg::plsbc_ans_s      link_ans,
  input  wire plsbc_pkg::plsbc_pkt_s rx_pkt,
  input  wire logic                 bulk_mode,
  input  wire logic                 bulk_initiator,
  input  wire logic                 bulk_receiver,
  input  wire logic                 rx_buf_release,
  input  wire logic                 resume_done,
  input  wire logic                 cmd_sent,
  input  wire logic                 cmd_done,
  input  wire logic                 host_run_trigger,
  // Received data stream
  input  wire logic                 rx_data_valid,
  output logic                      rx_data_ready,
  input  wire logic [7:0]           rx_data,
  output logic                      host_data_valid,
  input  wire logic                 host_data_ready,
  output logic      [7:0]           host_data,
  // Control outputs to the link engine
  output logic                      fsm_enable,
  output logic                      resume_request,
  output logic                      run_active,
  output logic                      ram_swap
);
  // ==========================================================================
  // Registers
  logic       rx_full;
  logic [1:0] bufs_used;
  logic       both_full;
  logic       fifo_init;
  logic       fifo_recv;
  logic       ping_to;
  logic       cont_stream;
  logic       no_fifo;
  logic       no_seal;
  logic       no_uart;
  logic       no_idle;
  logic [6:0] rx_count;
  logic [$clog2(PING_TO_CYC+1)-1:0] ping_cnt;
  logic       wr_stat;
  logic       wr_pol;
  logic       stat_clr;
  logic       next_ack;
  logic [7:0] stat_word;
  logic [7:0] pol_word;

  assign wr_stat  = clk_en && reg_wr && (reg_addr == `PLSBC_ADDR_STATUS_CTRL);
  assign wr_pol   = clk_en && reg_wr && (reg_addr == `PLSBC_ADDR_POLICY);
  assign stat_clr = wr_stat && reg_wdata[`PLSBC_BIT_RX_FULL];
  assign stat_word = {fsm_enable, rx_full, fifo_init, fifo_recv,
                      both_full, ping_to, resume_request, cont_stream};
  assign pol_word  = {no_fifo, no_seal, no_uart, no_idle, 3'h0, ram_swap}; // R21

  // ==========================================================================
  // Control bits written by the host
  // Reserved policy bits have no storage, which is why they always read back as zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fsm_enable  <= `PLSBC_RST_FSM_ENA; // R1
      cont_stream <= 1'h0;
      no_fifo     <= 1'h0;
      no_seal     <= 1'h0;
      no_uart     <= `PLSBC_RST_NO_UART; // R15
      no_idle     <= 1'h0;
      ram_swap    <= 1'h0;
    end else if (clk_en) begin
      if (wr_stat) begin
        fsm_enable  <= reg_wdata[`PLSBC_BIT_FSM_ENA]; // R1
        cont_stream <= reg_wdata[`PLSBC_BIT_CONT];
      end
      if (wr_pol) begin
        no_fifo  <= reg_wdata[`PLSBC_BIT_NO_FIFO];
        no_seal  <= reg_wdata[`PLSBC_BIT_NO_SEAL];
        no_uart  <= reg_wdata[`PLSBC_BIT_NO_UART];
        no_idle  <= reg_wdata[`PLSBC_BIT_NO_IDLE];
        ram_swap <= reg_wdata[`PLSBC_BIT_SWAP]; // R17
      end
    end
  end

  // ==========================================================================
  // Resume request and run trigger, both self-clearing
  // A new request outranks a completion in the same cycle, so a request is never lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resume_request <= 1'h0;
    end else if (clk_en) begin
      if (wr_stat && reg_wdata[`PLSBC_BIT_RESUME]) begin
        resume_request <= 1'h1; // R10
      end else if (resume_done) begin
        resume_request <= 1'h0; // R10
      end
    end
  end

  // A fresh trigger outranks the end of the previous command, so a trigger that lands
  // in the cycle in which the old command leaves is not lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_active <= 1'h0;
    end else if (clk_en) begin
      if (host_run_trigger) begin
        run_active <= 1'h1; // R19
      end else if (cmd_done && cont_stream && bulk_mode && bulk_initiator) begin
        run_active <= 1'h1; // R11
      end else if (cmd_sent) begin
        run_active <= 1'h0; // R19
      end
    end
  end

  // ==========================================================================
  // Receive buffer tracking; a new packet wins over a same-cycle clear
  // In bulk mode two buffers alternate; the count saturates so a stray packet cannot
  // wrap it, and leaving bulk mode forgets both buffers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_full   <= 1'h0;
      rx_count  <= 7'h00;
      bufs_used <= 2'h0;
      both_full <= 1'h0;
    end else if (clk_en) begin
      if (rx_pkt.valid) begin
        rx_full  <= 1'h1; // R2
        rx_count <= rx_pkt.count_m1; // R20
      end else if (stat_clr) begin
        rx_full <= 1'h0; // R3
      end
      if (!bulk_mode) begin
        bufs_used <= 2'h0;
        both_full <= 1'h0;
      end else begin
        case ({rx_pkt.valid, rx_buf_release})
          2'b10: begin
            bufs_used <= (bufs_used == 2'h2) ? 2'h2 : bufs_used + 2'h1;
            both_full <= (bufs_used != 2'h0); // R7
          end
          2'b01: begin
            bufs_used <= (bufs_used == 2'h0) ? 2'h0 : bufs_used - 2'h1;
            both_full <= 1'h0;
          end
          default: begin
            both_full <= (bufs_used == 2'h2);
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Bulk role mirrors
  // The role bits only follow the link engine; writes to them are ignored.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_init <= 1'h0;
      fifo_recv <= 1'h0;
    end else if (clk_en) begin
      fifo_init <= bulk_initiator; // R6
      fifo_recv <= bulk_receiver; // R6
    end
  end

  // ==========================================================================
  // Poll timeout monitor; it only drives the status flag
  // The counter parks at the limit, so the flag stays up until the next poll without
  // further counting; nothing else in the block reacts to it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ping_cnt <= '0;
      ping_to  <= 1'h0;
    end else if (clk_en) begin
      if (ping_seen) begin
        ping_cnt <= '0;
        ping_to  <= 1'h0; // R8
      end else if (ping_cnt != ($bits(ping_cnt))'(PING_TO_CYC)) begin
        ping_cnt <= ping_cnt + ($bits(ping_cnt))'(1);
      end else begin
        ping_to <= 1'h1; // R8 R9
      end
    end
  end

  // ==========================================================================
  // Answers to requests from the master
  // The decision uses the flags as they stand when the request is taken, so a packet
  // that lands in the same cycle does not yet count against that request.
  always_comb begin
    next_ack = 1'h1;
    case (link_req.kind)
      plsbc_pkg::PLSBC_REQ_DATA_OUT: begin
        next_ack = !rx_full && !both_full; // R4 R7
      end
      plsbc_pkg::PLSBC_REQ_SYS_FIFO: begin
        next_ack = !no_fifo; // R13
      end
      plsbc_pkg::PLSBC_REQ_SYS_SEAL: begin
        next_ack = !no_seal; // R14
      end
      plsbc_pkg::PLSBC_REQ_SYS_IDLE: begin
        next_ack = !no_idle; // R16
      end
      plsbc_pkg::PLSBC_REQ_UART: begin
        next_ack = !no_uart; // R15
      end
      default: begin
        next_ack = 1'h1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_ans <= '0;
    end else if (clk_en) begin
      link_ans.valid <= link_req.valid && fsm_enable; // R1
      link_ans.ack   <= next_ack;
    end
  end

  // ==========================================================================
  // Register read-back
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        `PLSBC_ADDR_STATUS_CTRL: begin
          reg_rdata <= stat_word;
        end
        `PLSBC_ADDR_POLICY: begin
          reg_rdata <= pol_word; // R21
        end
        `PLSBC_ADDR_RX_COUNT: begin
          reg_rdata <= {1'h0, rx_count}; // R20
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // Received data buffer
  // Received bytes wait here until the host drains them; ready falls once it is full.
  plsbc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (rx_data_valid),
    .in_ready  (rx_data_ready),
    .in_data   (rx_data),
    .out_valid (host_data_valid),
    .out_ready (host_data_ready),
    .out_data  (host_data)
  );
endmodule

// ===== plsbc_consts.svh
// Constants for the link buffer status and command policy registers.
`ifndef PLSBC_CONSTS_SVH
`define PLSBC_CONSTS_SVH
`define PLSBC_ADDR_STATUS_CTRL 8'h35
`define PLSBC_ADDR_POLICY      8'h36
`define PLSBC_ADDR_RX_COUNT    8'h39
`define PLSBC_BIT_FSM_ENA      7
`define PLSBC_BIT_RX_FULL      6
`define PLSBC_BIT_FIFO_INIT    5
`define PLSBC_BIT_FIFO_RECV    4
`define PLSBC_BIT_BOTH_FULL    3
`define PLSBC_BIT_PING_TO      2
`define PLSBC_BIT_RESUME       1
`define PLSBC_BIT_CONT         0
`define PLSBC_BIT_NO_FIFO      7
`define PLSBC_BIT_NO_SEAL      6
`define PLSBC_BIT_NO_UART      5
`define PLSBC_BIT_NO_IDLE      4
`define PLSBC_BIT_SWAP         0
`define PLSBC_RST_FSM_ENA      1'h1
`define PLSBC_RST_NO_UART      1'h1
`define PLSBC_PING_TO_US       268500
`define PLSBC_CLK_MHZ          25
`define PLSBC_PING_TO_CYC      (`PLSBC_PING_TO_US * `PLSBC_CLK_MHZ)
`endif

// ===== plsbc_pkg.sv
// Types shared by the link buffer control block.
package plsbc_pkg;
  typedef enum logic [2:0] {
    PLSBC_REQ_DATA_OUT = 3'h0,
    PLSBC_REQ_SYS_FIFO = 3'h1,
    PLSBC_REQ_SYS_SEAL = 3'h2,
    PLSBC_REQ_SYS_IDLE = 3'h3,
    PLSBC_REQ_UART     = 3'h4,
    PLSBC_REQ_OTHER    = 3'h5
  } plsbc_req_e;
  typedef struct packed {
    logic       valid;
    plsbc_req_e kind;
  } plsbc_req_s;
  typedef struct packed {
    logic valid;
    logic ack;
  } plsbc_ans_s;
  typedef struct packed {
    logic       valid;
    logic [6:0] count_m1;
  } plsbc_pkt_s;
endpackage

// ===== plsbc_fifo.sv
// Synchronous FIFO with valid and ready on both sides and registered read data.
`timescale 1ns/1ps
module plsbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             do_wr;
  logic             do_rd;
  logic             do_pop;

  // Read data sits in a register that counts as storage, so fill covers memory and out_data.
  assign do_wr  = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  assign do_rd  = (fill != (AW+1)'(out_valid)) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (clk_en && do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      fill      <= '0;
      in_ready  <= 1'h1;
      out_valid <= 1'h0;
      out_data  <= '0;
    end else if (clk_en) begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (do_rd) begin
        rd_ptr   <= rd_ptr + AW'(1);
        out_data <= mem[rd_ptr];
        out_valid <= 1'h1;
      end else if (out_ready) begin
        out_valid <= 1'h0;
      end
      case ({do_wr, do_pop})
        2'b10: begin
          fill     <= fill + (AW+1)'(1);
          in_ready <= (fill + (AW+1)'(1)) != (AW+1)'(DEPTH);
        end
        2'b01: begin
          fill     <= fill - (AW+1)'(1);
          in_ready <= 1'h1;
        end
        default: begin
          fill <= fill;
        end
      endcase
    end
  end
endmodule

// ===== plsbc_top_assertions.sv
// Port-level checker for the link buffer control block.
`timescale 1ns/1ps
module plsbc_top_assertions #(
  parameter int PING_TO_CYC = 20
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  // Register port
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_rdata,
  // Link events and controls
  input wire logic                  ping_seen,
  input wire plsbc_pkg::plsbc_req_s link_req,
  input wire plsbc_pkg::plsbc_ans_s link_ans,
  input wire plsbc_pkg::plsbc_pkt_s rx_pkt,
  input wire logic                  resume_done,
  input wire logic                  cmd_sent,
  input wire logic                  cmd_done,
  input wire logic                  host_run_trigger,
  input wire logic                  fsm_enable,
  input wire logic                  resume_request,
  input wire logic                  run_active
);
  // ==========================================================
  // Poll gap counter and checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);
  int quiet;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet <= 0;
    end else if (clk_en) begin
      if (ping_seen) begin
        quiet <= 0;
      end else if (quiet < PING_TO_CYC + 8) begin
        quiet <= quiet + 1;
      end
    end
  end
  AST_ANS_ON: assert property (
    link_req.valid && fsm_enable |=> link_ans.valid) else $error("no answer");
  AST_ANS_OFF: assert property (
    link_req.valid && !fsm_enable |=> !link_ans.valid) else $error("answer when off");
  AST_FULL_NACK: assert property (
    rx_pkt.valid ##[1:2] (link_req.valid && fsm_enable && link_req.kind ==
    plsbc_pkg::PLSBC_REQ_DATA_OUT) |=> !link_ans.ack) else $error("full not refused");
  AST_RESUME: assert property (
    resume_done && !reg_wr |-> ##[1:2] !resume_request) else $error("resume stuck");
  AST_RUN_SET: assert property (
    host_run_trigger && !cmd_sent |=> run_active) else $error("run not set");
  AST_RUN_CLR: assert property (
    cmd_sent && !host_run_trigger && !cmd_done |=> !run_active) else $error("run kept");
  AST_POL_ZERO: assert property (
    reg_rd && reg_addr == 8'h36 |=> reg_rdata[3:1] == 3'h0) else $error("unused bits");
  AST_PING_SET: assert property (
    reg_rd && reg_addr == 8'h35 && quiet > PING_TO_CYC + 3 |=> reg_rdata[2])
    else $error("timeout not shown");
  AST_PING_CLR: assert property (
    reg_rd && reg_addr == 8'h35 && quiet + 3 < PING_TO_CYC |=> !reg_rdata[2])
    else $error("false timeout");
  AST_RX_COUNT: assert property (
    rx_pkt.valid ##2 (reg_rd && reg_addr == 8'h39) |=>
    reg_rdata == {1'b0, $past(rx_pkt.count_m1, 3)}) else $error("count wrong");
endmodule

// ===== plsbc_mst_model.sv
// Link master model: presence polls, requests and packet arrivals.
`timescale 1ns/1ps
module plsbc_mst_model #(
  parameter int PING_GAP = 8
) (
  // Clock
  input  wire logic             clk,
  // Link events
  output logic                  ping_seen,
  output plsbc_pkg::plsbc_req_s link_req,
  output plsbc_pkg::plsbc_pkt_s rx_pkt
);
  logic ping_on = 1'b1;
  int   gap = 0;
  initial begin
    ping_seen = 1'b0;
    link_req = '0;
    rx_pkt = '0;
  end
  // Polls arrive every PING_GAP + 1 cycles while enabled.
  always @(negedge clk) begin
    gap <= (gap == PING_GAP) ? 0 : gap + 1;
    ping_seen <= ping_on && gap == 0;
  end
  task automatic req(input plsbc_pkg::plsbc_req_e k);
    @(negedge clk) link_req <= {1'b1, k};
    @(negedge clk) link_req <= '0;
  endtask
  task automatic pkt(input logic [6:0] c);
    @(negedge clk) rx_pkt <= {1'b1, c};
    @(negedge clk) rx_pkt <= '0;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the link buffer control block.
`timescale 1ns/1ps
module tb;
  localparam int PT = 20;
  localparam plsbc_pkg::plsbc_req_e DOUT = plsbc_pkg::PLSBC_REQ_DATA_OUT;
  logic clk, sys_rst, clk_en, reg_wr, reg_rd, ping_seen, bulk_mode;
  logic bulk_initiator, bulk_receiver, rx_buf_release, resume_done, cmd_sent;
  logic cmd_done, host_run_trigger, rx_data_valid, rx_data_ready, host_data_valid;
  logic host_data_ready, fsm_enable, resume_request, run_active, ram_swap;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_data, host_data, p;
  logic [6:0] n;
  logic [7:0] q[$];
  int bad_count, checked, i, j;
  plsbc_pkg::plsbc_req_s link_req;
  plsbc_pkg::plsbc_ans_s link_ans;
  plsbc_pkg::plsbc_pkt_s rx_pkt;
  plsbc_top #(.PING_TO_CYC(PT)) u_dut (.clk, .sys_rst, .clk_en, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .ping_seen, .link_req, .link_ans, .rx_pkt,
    .bulk_mode, .bulk_initiator, .bulk_receiver, .rx_buf_release, .resume_done,
    .cmd_sent, .cmd_done, .host_run_trigger, .rx_data_valid, .rx_data_ready, .rx_data,
    .host_data_valid, .host_data_ready, .host_data, .fsm_enable, .resume_request,
    .run_active, .ram_swap);
  plsbc_mst_model u_mst (.clk, .ping_seen, .link_req, .rx_pkt);
  // ==========================================================
  // Bus tasks and expectations
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk);
    reg_rd = 1'b0;
    cmp(reg_rdata, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic ans(input plsbc_pkg::plsbc_req_e k, input logic a);
    u_mst.req(k);
    cmp({6'h0, link_ans}, {6'h0, 1'b1, a});
  endtask
  function automatic logic exp_ack(input logic [7:0] c, input plsbc_pkg::plsbc_req_e k);
    case (k)
      plsbc_pkg::PLSBC_REQ_SYS_FIFO: return !c[7];
      plsbc_pkg::PLSBC_REQ_SYS_SEAL: return !c[6];
      plsbc_pkg::PLSBC_REQ_UART:     return !c[5];
      plsbc_pkg::PLSBC_REQ_SYS_IDLE: return !c[4];
      default:                       return 1'b1;
    endcase
  endfunction
  task automatic print_verdict;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
  // ==========================================================
  // Scenarios
  initial begin
    {sys_rst, clk_en, reg_wr, reg_rd, bulk_mode, bulk_initiator} = 6'h30;
    {bulk_receiver, rx_buf_release, resume_done, cmd_sent, cmd_done} = '0;
    {host_run_trigger, rx_data_valid, host_data_ready} = '0;
    {reg_addr, reg_wdata, rx_data} = '0;
    {bad_count, checked} = '0;
    void'($urandom(32'hba8d));
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    rc(8'h35, 8'h80);
    rc(8'h36, 8'h20);
    rc(8'h39, 8'h00);
    rc(8'h40, 8'h00);
    for (i = 0; i < 8; i++) begin
      p = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      wr(8'h36, p);
      rc(8'h36, p & 8'hf1);
      cmp({7'h0, ram_swap}, {7'h0, p[0]});
      for (j = 1; j < 5; j++) ans(plsbc_pkg::plsbc_req_e'(3'(j)),
        exp_ack(p, plsbc_pkg::plsbc_req_e'(3'(j))));
    end
    wr(8'h36, 8'h00);
    ans(DOUT, 1'b1);
    n = 7'($urandom());
    u_mst.pkt(n);
    ans(DOUT, 1'b0);
    rc(8'h39, {1'b0, n});
    rc(8'h35, 8'hc0);
    wr(8'h35, 8'hc0);
    rc(8'h35, 8'h80);
    ans(DOUT, 1'b1);
    wr(8'h35, 8'h00);
    u_mst.req(DOUT);
    cmp({7'h0, link_ans.valid}, 8'h00);
    cmp({7'h0, fsm_enable}, 8'h00);
    wr(8'h35, 8'h80);
    {bulk_mode, bulk_initiator} = 2'b11;
    n = 7'($urandom());
    u_mst.pkt(n);
    rc(8'h39, {1'b0, n});
    u_mst.pkt(~n);
    wr(8'h35, 8'hc0);
    rc(8'h35, 8'ha8);
    ans(DOUT, 1'b0);
    pulse(rx_buf_release);
    rc(8'h35, 8'ha0);
    ans(DOUT, 1'b1);
    {bulk_initiator, bulk_receiver} = 2'b01;
    rc(8'h35, 8'h90);
    {bulk_initiator, bulk_receiver} = 2'b10;
    wr(8'h35, 8'h81);
    pulse(host_run_trigger);
    cmp({7'h0, run_active}, 8'h01);
    pulse(cmd_sent);
    cmp({7'h0, run_active}, 8'h00);
    pulse(cmd_done);
    cmp({7'h0, run_active}, 8'h01);
    pulse(cmd_sent);
    wr(8'h35, 8'h80);
    pulse(cmd_done);
    cmp({7'h0, run_active}, 8'h00);
    clk_en = 1'b0;
    pulse(host_run_trigger);
    cmp({7'h0, run_active}, 8'h00);
    clk_en = 1'b1;
    {bulk_mode, bulk_initiator} = 2'b00;
    wr(8'h35, 8'h82);
    rc(8'h35, 8'h82);
    cmp({7'h0, resume_request}, 8'h01);
    pulse(resume_done);
    rc(8'h35, 8'h80);
    u_mst.ping_on = 1'b0;
    repeat (PT + 4) @(negedge clk);
    rc(8'h35, 8'h84);
    cmp({7'h0, fsm_enable}, 8'h01);
    u_mst.ping_on = 1'b1;
    repeat (12) @(negedge clk);
    rc(8'h35, 8'h80);
    // Fill the buffer while the drain side stalls, then empty it.
    rx_data_valid = 1'b1;
    rx_data = 8'($urandom());
    for (i = 0; i < 40; i++) begin
      j = rx_data_ready;
      if (j) q.push_back(rx_data);
      @(negedge clk);
      if (j) rx_data = 8'($urandom());
    end
    rx_data_valid = 1'b0;
    cmp(8'(q.size()), 8'h20);
    host_data_ready = 1'b1;
    for (i = 0; i < 80 && q.size() > 0; i++) begin
      if (host_data_valid) cmp(host_data, q.pop_front());
      @(negedge clk);
    end
    cmp(8'(q.size()), 8'h00);
    print_verdict();
  end
endmodule
bind plsbc_top plsbc_top_assertions #(.PING_TO_CYC(PING_TO_CYC)) u_chk (.clk, .sys_rst,
  .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .ping_seen, .link_req, .link_ans,
  .rx_pkt, .resume_done, .cmd_sent, .cmd_done, .host_run_trigger, .fsm_enable,
  .resume_request, .run_active);
